/* pkg/eeprom_fe_defs.vh */
// Constants for the two-wire serial slave front end.
// Assumes inclusion by bare name from the design files.
`ifndef EEPROM_FE_DEFS_VH
`define EEPROM_FE_DEFS_VH

// Byte framing
`define BYTE_BITS 4'h8
`define BIT_CNT_W 4
// Slave address field positions
`define SA_TYPE_HI 7
`define SA_TYPE_LO 4
`define SA_SEL_HI 3
`define SA_SEL_LO 1
`define SA_RW_BIT 0
// Array address: low nibble of upper byte plus lower byte
`define ADDR_W 12
`define ADDR_HI_W 4
`define ADDR_TOP_BIT 11
// Write data FIFO shape
`define FIFO_W 8
`define FIFO_D 4
// Controller states
`define ST_IDLE 3'h0
`define ST_DEVADDR 3'h1
`define ST_ADDR_HI 3'h2
`define ST_ADDR_LO 3'h3
`define ST_WDATA 3'h4
`define ST_RDATA 3'h5
`define ST_RACK 3'h6
`define ST_IGNORE 3'h7

`endif

/* hw/byte_fifo.v */
// Small synchronous FIFO for received write data.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module byte_fifo #(
  parameter W = 8,
  parameter D = 4,
  parameter AW = 2
) (
  input wire mclk,
  input wire sys_rst,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  localparam [AW:0] FULL = D;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  assign in_ready = (count_r != FULL);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge mclk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push & ~pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop & ~push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

/* hw/eeprom_serial_slave_front_end.v */
// Two-wire serial slave front end: start/stop, slave address, array address, ack.
// Assumes bus pins arrive asynchronously; program cycle and read data live outside.
//
// Operation
// - Address byte: type, select, direction bit
// - Type field must match own code
// - Select field must match chip-select pins
// - Select bits map highest pin first
// - Direction bit one reads, zero writes
// - Receiver acks by pulling low ninth clock
// - Transmitter releases line, awaits acknowledge
// - Upper address byte, then lower byte
// - Use low nibble of upper byte only
// - Data line only pulled low or released
// - Serial clock is only timing, never driven
// - Data changes only while clock low
// - Start: data falls, clock high
// - Stop: data rises, clock high, standby
// - Write-protect pin guards upper half
// - Protected write: ack addresses, refuse data
// - Write-protect defaults unprotected when open
// - Receiver ack continues, no ack ends
// - Busy programming: ignore address, no ack
// - Refused data: no program cycle at stop
`timescale 1ns/10ps
`include "eeprom_fe_defs.vh"
module eeprom_serial_slave_front_end #(
  // Device type code; value is arbitrary
  parameter [3:0] DEV_TYPE = 4'h6
) (
  input wire mclk,
  input wire sys_rst,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o_r,
  output reg sda_oe_r,
  input wire chip_select_pin_high,
  input wire chip_select_pin_mid,
  input wire chip_select_pin_low,
  input wire write_protect,
  input wire prog_busy,
  output reg prog_start_r,
  output reg [11:0] mem_addr_r,
  output reg addr_load_r,
  output reg read_dir_r,
  output reg rd_req_r,
  input wire [7:0] rd_byte,
  output wire [7:0] wr_data,
  output wire wr_valid,
  input wire wr_ready,
  output reg selected_r,
  output reg wr_refused_r
);
  // Pin synchronisers: stage one feeds stage two only
  reg [5:0] sync1_r;
  reg [5:0] sync2_r;
  reg scl_d_r;
  reg sda_d_r;
  wire scl_s;
  wire sda_s;
  wire wp_s;
  wire [2:0] cs_s;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;

  reg [2:0] state_r;
  reg [3:0] bitcnt_r;
  reg ack_phase_r;
  reg [7:0] rx_sh_r;
  reg [7:0] tx_sh_r;
  reg [3:0] addr_hi_r;
  reg data_seen_r;
  reg [7:0] push_data_r;
  reg push_r;
  wire fifo_in_ready;
  wire dev_match;
  wire protected_loc;

  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sync1_r <= 6'h3F;
      sync2_r <= 6'h3F;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      sync1_r <= {scl_i, sda_i, write_protect, chip_select_pin_high,
                  chip_select_pin_mid, chip_select_pin_low};
      sync2_r <= sync1_r;
      scl_d_r <= sync2_r[5];
      sda_d_r <= sync2_r[4];
    end
  end

  assign scl_s = sync2_r[5];
  assign sda_s = sync2_r[4];
  // Open pin sits low outside, so a floating input reads unprotected
  assign wp_s = sync2_r[3];
  assign cs_s = sync2_r[2:0];
  // Edges of the master's clock are the only timing for bits
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_cond = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // Type and select comparison, held off while programming
  assign dev_match = (rx_sh_r[`SA_TYPE_HI:`SA_TYPE_LO] == DEV_TYPE)
    && (rx_sh_r[`SA_SEL_HI:`SA_SEL_LO] == cs_s)
    && ~prog_busy;
  assign protected_loc = wp_s & mem_addr_r[`ADDR_TOP_BIT];

  byte_fifo #(
    .W(`FIFO_W),
    .D(`FIFO_D),
    .AW(2)
  ) u_wr_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_data(push_data_r),
    .in_valid(push_r),
    .in_ready(fifo_in_ready),
    .out_data(wr_data),
    .out_valid(wr_valid),
    .out_ready(wr_ready)
  );

  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_r <= `ST_IDLE;
      bitcnt_r <= 4'h0;
      ack_phase_r <= 1'b0;
      rx_sh_r <= 8'h00;
      tx_sh_r <= 8'h00;
      addr_hi_r <= 4'h0;
      data_seen_r <= 1'b0;
      push_data_r <= 8'h00;
      push_r <= 1'b0;
      sda_o_r <= 1'b0;
      sda_oe_r <= 1'b0;
      prog_start_r <= 1'b0;
      mem_addr_r <= 12'h000;
      addr_load_r <= 1'b0;
      read_dir_r <= 1'b0;
      rd_req_r <= 1'b0;
      selected_r <= 1'b0;
      wr_refused_r <= 1'b0;
    end
    else
    begin
      // Line is only ever pulled low, never driven high
      sda_o_r <= 1'b0;
      push_r <= 1'b0;
      prog_start_r <= 1'b0;
      addr_load_r <= 1'b0;
      rd_req_r <= 1'b0;
      if (start_cond)
      begin
        state_r <= `ST_DEVADDR;
        bitcnt_r <= 4'h0;
        ack_phase_r <= 1'b0;
        sda_oe_r <= 1'b0;
        data_seen_r <= 1'b0;
        wr_refused_r <= 1'b0;
        selected_r <= 1'b0;
      end
      else if (stop_cond)
      begin
        // Program only after accepted, unrefused write data
        if (data_seen_r & ~wr_refused_r & ~read_dir_r)
        begin
          prog_start_r <= 1'b1;
        end
        state_r <= `ST_IDLE;
        sda_oe_r <= 1'b0;
        ack_phase_r <= 1'b0;
        selected_r <= 1'b0;
        data_seen_r <= 1'b0;
      end
      else
      begin
        case (state_r)
          `ST_DEVADDR, `ST_ADDR_HI, `ST_ADDR_LO, `ST_WDATA:
          begin
            // Sample on rising clock; data is stable while clock high
            if (scl_rise && !ack_phase_r && bitcnt_r != `BYTE_BITS)
            begin
              rx_sh_r <= {rx_sh_r[6:0], sda_s};
              bitcnt_r <= bitcnt_r + 4'h1;
            end
            else if (scl_fall && !ack_phase_r && bitcnt_r == `BYTE_BITS)
            begin
              ack_phase_r <= 1'b1;
              case (state_r)
                `ST_DEVADDR:
                begin
                  if (dev_match)
                  begin
                    sda_oe_r <= 1'b1;
                    selected_r <= 1'b1;
                    read_dir_r <= rx_sh_r[`SA_RW_BIT];
                    rd_req_r <= rx_sh_r[`SA_RW_BIT];
                  end
                  else
                  begin
                    state_r <= `ST_IGNORE;
                  end
                end
                `ST_ADDR_HI:
                begin
                  sda_oe_r <= 1'b1;
                  addr_hi_r <= rx_sh_r[`ADDR_HI_W-1:0];
                end
                `ST_ADDR_LO:
                begin
                  sda_oe_r <= 1'b1;
                  mem_addr_r <= {addr_hi_r, rx_sh_r};
                  addr_load_r <= 1'b1;
                end
                default:
                begin
                  // Refuse protected data, or data the FIFO cannot take
                  if (protected_loc | ~fifo_in_ready)
                  begin
                    wr_refused_r <= 1'b1;
                    state_r <= `ST_IGNORE;
                  end
                  else
                  begin
                    sda_oe_r <= 1'b1;
                    push_data_r <= rx_sh_r;
                    push_r <= 1'b1;
                    data_seen_r <= 1'b1;
                  end
                end
              endcase
            end
            else if (scl_fall && ack_phase_r)
            begin
              // End of ninth clock: release line back to transmitter, or after a read address drive bit 7 of rd_byte
              ack_phase_r <= 1'b0;
              bitcnt_r <= 4'h0;
              sda_oe_r <= 1'b0;
              case (state_r)
                `ST_DEVADDR:
                begin
                  if (read_dir_r)
                  begin
                    state_r <= `ST_RDATA;
                    sda_oe_r <= ~rd_byte[7];
                    tx_sh_r <= {rd_byte[6:0], 1'b0};
                    bitcnt_r <= 4'h1;
                  end
                  else
                  begin
                    state_r <= `ST_ADDR_HI;
                  end
                end
                `ST_ADDR_HI:
                begin
                  state_r <= `ST_ADDR_LO;
                end
                default:
                begin
                  state_r <= `ST_WDATA;
                end
              endcase
            end
          end
          `ST_RDATA:
          begin
            if (scl_fall)
            begin
              if (bitcnt_r == 4'h0)
              begin
                sda_oe_r <= ~rd_byte[7];
                tx_sh_r <= {rd_byte[6:0], 1'b0};
                bitcnt_r <= 4'h1;
              end
              else if (bitcnt_r != `BYTE_BITS)
              begin
                sda_oe_r <= ~tx_sh_r[7];
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                bitcnt_r <= bitcnt_r + 4'h1;
              end
              else
              begin
                sda_oe_r <= 1'b0;
                state_r <= `ST_RACK;
              end
            end
          end
          `ST_RACK:
          begin
            if (scl_rise)
            begin
              if (!sda_s)
              begin
                rd_req_r <= 1'b1;
                bitcnt_r <= 4'h0;
                state_r <= `ST_RDATA;
              end
              else
              begin
                state_r <= `ST_IGNORE;
              end
            end
          end
          `ST_IGNORE:
          begin
            sda_oe_r <= 1'b0;
          end
          default:
          begin
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

/* tb/fe_props.sv */
// Checker for the two-wire slave front end.
// Assumes binding to the front end top module.
`timescale 1ns/10ps
module fe_props (
  input wire mclk,
  input wire sys_rst,
  input wire scl_i,
  input wire sda_i,
  input wire sda_o_r,
  input wire sda_oe_r,
  input wire prog_busy,
  input wire prog_start_r,
  input wire addr_load_r,
  input wire read_dir_r,
  input wire rd_req_r,
  input wire selected_r,
  input wire wr_refused_r
);
  reg scl_q;
  reg sda_q;
  always @(posedge mclk)
  begin
    scl_q <= scl_i;
    sda_q <= sda_i;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence stop_seen;
    scl_q && $past(scl_q) && sda_q && !$past(sda_q);
  endsequence
  a_drive_low_only: assert property (sda_oe_r |-> !sda_i && sda_o_r == 1'b0)
    else $error("data line driven high");
  a_oe_scl_low: assert property ($changed(sda_oe_r) |-> !scl_i)
    else $error("data changed with clock high");
  a_busy_no_ack: assert property (prog_busy && !selected_r |-> !sda_oe_r)
    else $error("ack while busy");
  a_stop_deselect: assert property (stop_seen |-> ##[1:8] !selected_r)
    else $error("still selected after stop");
  a_prog_clean: assert property (prog_start_r |-> !wr_refused_r ##1 !prog_start_r)
    else $error("bad program start");
  a_addr_write: assert property (addr_load_r |-> selected_r && !read_dir_r)
    else $error("address load outside write");
  a_rd_req_read: assert property (rd_req_r |-> selected_r && read_dir_r)
    else $error("read request outside read");
  a_ack_selected: assert property ($rose(sda_oe_r) |-> ##[0:4] selected_r)
    else $error("drive while unaddressed");
endmodule

bind eeprom_serial_slave_front_end fe_props props (.mclk, .sys_rst, .scl_i, .sda_i,
  .sda_o_r, .sda_oe_r, .prog_busy, .prog_start_r, .addr_load_r, .read_dir_r,
  .rd_req_r, .selected_r, .wr_refused_r);

/* tb/bus_master_model.sv */
// Two-wire bus master model, 200 ns clock period.
// Assumes a pull-up on the data line outside this model; the clock is driven both ways.
`timescale 1ns/10ps
module bus_master_model (
  output wire scl,
  output wire sda_pull,
  input wire sda
);
  reg scl_low = 1'b0;
  reg sda_low = 1'b0;
  assign scl = !scl_low;
  assign sda_pull = sda_low;
  task start;
  begin
    sda_low = 1'b1;
    #100 scl_low = 1'b1;
  end
  endtask
  task stop;
  begin
    #40 sda_low = 1'b1;
    #90 scl_low = 1'b0;
    #100 sda_low = 1'b0;
    #300;
  end
  endtask
  // Data set while clock low, sampled at end of high
  task slot(input bit drive_low, output bit seen);
  begin
    #40 sda_low = drive_low;
    #90 scl_low = 1'b0;
    #70 seen = sda;
    scl_low = 1'b1;
  end
  endtask
  task xfer(input [7:0] tx, input bit mack, output [7:0] rx, output bit nak);
    integer i;
  begin
    for (i = 7; i >= 0; i = i - 1)
      slot(!tx[i], rx[i]);
    slot(mack, nak);
  end
  endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the two-wire slave front end.
// Assumes the bus master model and checker files.
`timescale 1ns/10ps
module tb;
  localparam [3:0] TYPE = 4'h6; // Arbitrary type code
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg [2:0] cs = 3'h0;
  reg write_protect = 1'b0;
  reg prog_busy = 1'b0;
  reg [7:0] rd_byte = 8'h00;
  reg wr_ready = 1'b0;
  wire scl;
  wire pull;
  wire sda_o_r;
  wire sda_oe_r;
  wire prog_start_r;
  wire addr_load_r;
  wire read_dir_r;
  wire rd_req_r;
  wire wr_valid;
  wire selected_r;
  wire wr_refused_r;
  wire [11:0] mem_addr_r;
  wire [7:0] wr_data;
  wire sda = !(pull || (sda_oe_r && !sda_o_r));
  integer n_errors = 0;
  integer tests_run = 0;
  integer n_prog = 0;
  integer n_rdreq = 0;
  reg [7:0] rx;
  reg nak;
  reg [7:0] d [0:4];
  initial
    forever #12.5 mclk = ~mclk;
  always @(posedge mclk)
    if (prog_start_r === 1'b1)
      n_prog <= n_prog + 1;
  always @(posedge mclk)
    if (rd_req_r === 1'b1)
      n_rdreq <= n_rdreq + 1;
  function [11:0] exp_addr(input [7:0] h, input [7:0] l);
  begin
    exp_addr = {h[3:0], l};
  end
  endfunction
  bus_master_model m (.scl(scl), .sda_pull(pull), .sda(sda));
  eeprom_serial_slave_front_end #(.DEV_TYPE(TYPE)) uut (.mclk, .sys_rst, .scl_i(scl),
    .sda_i(sda), .sda_o_r, .sda_oe_r, .chip_select_pin_high(cs[2]),
    .chip_select_pin_mid(cs[1]), .chip_select_pin_low(cs[0]), .write_protect,
    .prog_busy, .prog_start_r, .mem_addr_r, .addr_load_r, .read_dir_r, .rd_req_r,
    .rd_byte, .wr_data, .wr_valid, .wr_ready, .selected_r, .wr_refused_r);
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
  begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  task head(input [3:0] ty, input [2:0] sel, input bit rw, input bit en);
  begin
    m.start();
    m.xfer({ty, sel, rw}, 1'b0, rx, nak);
    chk("addr ack", nak, en);
  end
  endtask
  task wr(input [7:0] b, input bit en);
  begin
    m.xfer(b, 1'b0, rx, nak);
    chk("data ack", nak, en);
  end
  endtask
  task pop(input [7:0] exp);
    integer k;
  begin
    k = 0;
    @(negedge mclk);
    while (wr_valid !== 1'b1 && k < 20)
    begin
      @(negedge mclk);
      k = k + 1;
    end
    chk("wr data", wr_data, exp);
    @(posedge mclk);
    wr_ready <= 1'b1;
    @(posedge mclk);
    wr_ready <= 1'b0;
  end
  endtask
  initial
  begin : main
    integer i;
    reg [7:0] hi;
    reg [7:0] lo;
    i = $urandom(57);
    for (i = 0; i < 5; i = i + 1)
      d[i] = $urandom;
    cs <= $urandom;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge mclk);
    // Fill the FIFO until a byte is refused
    hi = $urandom;
    lo = $urandom;
    head(TYPE, cs, 1'b0, 1'b0);
    wr(hi, 1'b0);
    wr(lo, 1'b0);
    chk("addr", mem_addr_r, exp_addr(hi, lo));
    for (i = 0; i < 5; i = i + 1)
      wr(d[i], i == 4);
    m.stop();
    chk("prog", n_prog, 0);
    chk("refused", wr_refused_r, 1'b1);
    chk("selected", selected_r, 1'b0);
    for (i = 0; i < 4; i = i + 1)
      pop(d[i]);
    // Protection: lower half writable, upper half refused
    @(posedge mclk);
    write_protect <= 1'b1;
    for (i = 0; i < 2; i = i + 1)
    begin
      hi = $urandom;
      hi[3] = i;
      head(TYPE, cs, 1'b0, 1'b0);
      wr(hi, 1'b0);
      wr(lo, 1'b0);
      wr(d[i], i == 1);
      m.stop();
      chk("prog", n_prog, 1);
    end
    pop(d[0]);
    // Wrong select, wrong type, busy
    head(TYPE, cs ^ 3'h1 << ($urandom % 3), 1'b0, 1'b1);
    m.stop();
    head(TYPE ^ 4'h8 >> ($urandom % 4), cs, 1'b0, 1'b1);
    m.stop();
    @(posedge mclk);
    prog_busy <= 1'b1;
    head(TYPE, cs, 1'b0, 1'b1);
    m.stop();
    @(posedge mclk);
    prog_busy <= 1'b0;
    rd_byte <= $urandom;
    // Read two bytes, ack then no ack
    head(TYPE, cs, 1'b1, 1'b0);
    m.xfer(8'hff, 1'b1, rx, nak);
    chk("rd byte", rx, rd_byte);
    m.xfer(8'hff, 1'b0, rx, nak);
    chk("rd byte", rx, rd_byte);
    m.stop();
    chk("read dir", read_dir_r, 1'b1);
    chk("rd req", n_rdreq, 2);
    chk("prog", n_prog, 1);
    end_of_test();
  end
  initial
  begin
    #500000;
    n_errors = n_errors + 1;
    end_of_test();
  end
endmodule
